// *** design/wkf_crc16.sv ***
// byte-serial CRC-16 accumulator, one per wake filter
// assumes clear and enable are one-cycle pulses on the system clock
`timescale 1ns/1ns
module wkf_crc16
   import wkf_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        clear_i,
   input  wire logic        en_i,
   input  wire logic [7:0]  data_i,
   output logic      [15:0] crc_o
);

   logic [15:0] next_crc;

   // =====================================================================
   // eight bit steps, lsb first
   always_comb
   begin
      next_crc = crc_o;
      for (int i = 0; i < 8; i++)
         next_crc = (next_crc[0] ^ data_i[i]) ? ((next_crc >> 1) ^ CRC_POLY_REV)
                                              : (next_crc >> 1);
   end

   // =====================================================================
   // accumulator
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         crc_o <= CRC_INIT;
      else if (clear_i)
         crc_o <= CRC_INIT;
      else if (en_i)
         crc_o <= next_crc;
   end

endmodule : wkf_crc16

// *** design/wkf_filter_mem.sv ***
// eight-word store behind the sequential wake filter address
// assumes the caller supplies the word pointer and the byte lanes
`timescale 1ns/1ns
module wkf_filter_mem
   import wkf_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wr_i,
   input  wire logic [2:0] ptr_i,
   input  wire logic [3:0] be_i,
   input  wire logic [31:0] wdata_i,
   output wkf_words_t      words_o
);

   // =====================================================================
   // storage, written lane by lane
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int k = 0; k < 8; k++)
            words_o[k] <= RST_WORD;
      end
      else if (wr_i)
      begin
         for (int b = 0; b < 4; b++)
            if (be_i[b])
               words_o[ptr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
      end
   end

endmodule : wkf_filter_mem

// *** design/wkf_pkg.sv ***
// constants, field layouts and carrier types for the wake filter and phy glue block
// assumes one 25 MHz system clock and a 32-bit register port with byte lanes
//
// Operation
// - eight successive writes to one address fill filter words zero to seven
// - word pointer steps only when lane 3 (lane 0 big-endian) is accessed
// - reads of the filter address return the words in order, same pointer
// - per-filter 31-bit mask picks frame bytes from offset for CRC; bit 31 zero
// - 4-bit command: bit 0 enable, bit 3 multicast or unicast, bits 2:1 reserved
// - each filter holds a 16-bit CRC compared against CRC of selected bytes
// - no clock is gated on power-down; receive path keeps running
// - power-management interrupt rises on a valid wake-up frame
// - a valid wake-up frame during power-down also leaves power-down
// - reading power-management control and status clears the pending interrupt
// - flow-control bit sends pause in full duplex, back-pressure in half duplex
// - 7-bit field sets transmit clock delay-line length
// - separate 7-bit field sets receive clock delay-line length
// - enable bits switch each delay line in; zero bypasses it
// - each delay line has one hundred selectable elements
// - DMA suspends without descriptors; writing zero to poll demand resumes it
// - MAC configuration holds transmitter enable bit 3, receiver enable bit 2
package wkf_pkg;

   // =====================================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_MAC_CONF   = 8'h00;
   localparam logic [7:0] OFS_TX_POLL    = 8'h04;
   localparam logic [7:0] OFS_RX_POLL    = 8'h08;
   localparam logic [7:0] OFS_WAKE_FILT  = 8'h28;
   localparam logic [7:0] OFS_PMT_CTRL   = 8'h2C;
   localparam logic [7:0] OFS_PHY_GLUE   = 8'h30;
   localparam logic [7:0] OFS_RGMII_DLY  = 8'h34;

   // =====================================================================
   // field positions
   localparam int MAC_RX_EN_BIT   = 2;
   localparam int MAC_TX_EN_BIT   = 3;
   localparam int MAC_DUPLEX_BIT  = 11;
   localparam int MAC_BIG_END_BIT = 20;
   localparam int PMT_PDOWN_BIT   = 0;
   localparam int PMT_WAKE_EN_BIT = 2;
   localparam int PMT_RCVD_BIT    = 6;
   localparam int PMT_PTR_LSB     = 24;
   localparam int PMT_PTR_RST_BIT = 31;
   localparam int CMD_EN_BIT      = 0;
   localparam int CMD_MCAST_BIT   = 3;

   // =====================================================================
   // reset values and fixed figures
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;
   localparam logic [15:0] RST_GLUE      = 16'h0000;
   localparam logic [15:0] RST_DLY       = 16'h0000;
   localparam logic [2:0]  PTR_LAST      = 3'h7;
   localparam logic [6:0]  DLY_TAP_MAX   = 7'h63;    // 100 elements, taps 0..99
   localparam logic [10:0] MASK_SPAN     = 11'h01F;  // 31 masked bytes
   localparam logic [10:0] BYTE_CNT_MAX  = 11'h7FF;
   localparam logic [3:0]  NIB_PREAMBLE  = 4'h5;
   localparam logic [3:0]  NIB_SFD_HI    = 4'hD;
   localparam logic [15:0] CRC_INIT      = 16'hFFFF;
   localparam logic [15:0] CRC_POLY_REV  = 16'hA001;  // x^16+x^15+x^2+1, lsb first

   // =====================================================================
   // types
   typedef logic [7:0][31:0] wkf_words_t;

   typedef enum logic [1:0] {
      RX_IDLE     = 2'b00,
      RX_PREAMBLE = 2'b01,
      RX_DATA     = 2'b10,
      RX_DONE     = 2'b11
   } wkf_rx_e;

   typedef struct packed {
      logic [30:0] mask;
      logic [3:0]  cmd;
      logic [7:0]  offset;
      logic [15:0] crc;
   } wkf_filter_s;

   typedef struct packed {
      logic       rmii_mode;    // bit 14
      logic [1:0] rgmii_clk;    // bits 13:12
      logic       rmii_clk;     // bit 11
      logic       speed_100;    // bit 10
      logic       flow_ctrl;    // bit 9
      logic [2:0] intf_sel;     // bits 2:0
   } wkf_glue_s;

   typedef struct packed {
      logic       rx_en;
      logic       tx_en;
      logic [6:0] rx_taps;
      logic [6:0] tx_taps;
   } wkf_dly_s;

   // =====================================================================
   // functions
   // slice filter i out of the eight loaded words
   function automatic wkf_filter_s get_filter(input wkf_words_t w, input int i);
      wkf_filter_s f;
      f.mask   = w[i][30:0];
      f.cmd    = w[4][i*8 +: 4];
      f.offset = w[5][i*8 +: 8];
      f.crc    = w[6 + i/2][(i%2)*16 +: 16];
      return f;
   endfunction : get_filter

   // true when frame byte cnt is selected by filter f
   function automatic logic byte_sel(input wkf_filter_s f, input logic [10:0] cnt);
      logic [10:0] rel;
      rel = cnt - {3'h0, f.offset};
      return (cnt >= {3'h0, f.offset}) && (rel < MASK_SPAN) && f.mask[rel[4:0]];
   endfunction : byte_sel

   // saturate a delay-line length to the last element
   function automatic logic [6:0] clamp_taps(input logic [6:0] v);
      return (v > DLY_TAP_MAX) ? DLY_TAP_MAX : v;
   endfunction : clamp_taps

endpackage : wkf_pkg

// *** design/wkf_top.sv ***
// wake-up frame filters, power-management control and phy glue registers
// assumes a plain register port on clk_i and an MII-style nibble receive link
// whose clock and data arrive asynchronously and are sampled here
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module wkf_top
   import wkf_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic [3:0]  reg_be_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // receive link from the phy
   input  wire logic        rx_clk_i,
   input  wire logic        rx_dv_i,
   input  wire logic [3:0]  rxd_i,
   // mac controls
   output logic             mac_tx_en_o,
   output logic             mac_rx_en_o,
   output logic             tx_poll_o,
   output logic             rx_poll_o,
   output logic             pause_tx_o,
   output logic             backpressure_o,
   // glue
   output wkf_glue_s        glue_o,
   output wkf_dly_s         dly_o,
   // power management
   output logic             power_down_o,
   output logic             pmt_irq_o
);

   // =====================================================================
   // register state
   logic [31:0] mac_configuration;
   logic [15:0] phy_glue_config;
   logic [15:0] rgmii_delay_config;
   logic        pd_mode;
   logic        wake_en;
   logic        wake_rcvd;
   logic [2:0]  filt_ptr;
   wkf_words_t  filt_words;

   logic        sel_mac;
   logic        sel_filt;
   logic        sel_pmt;
   logic        sel_glue;
   logic        sel_dly;
   logic        ptr_lane;
   logic        wake_hit;

   // address decode
   assign sel_mac  = (reg_addr_i == OFS_MAC_CONF);
   assign sel_filt = (reg_addr_i == OFS_WAKE_FILT);
   assign sel_pmt  = (reg_addr_i == OFS_PMT_CTRL);
   assign sel_glue = (reg_addr_i == OFS_PHY_GLUE);
   assign sel_dly  = (reg_addr_i == OFS_RGMII_DLY);

   // lane that moves the filter pointer depends on endianness
   assign ptr_lane = mac_configuration[MAC_BIG_END_BIT] ? reg_be_i[0]
                                                        : reg_be_i[3];

   // =====================================================================
   // plain configuration registers, whole-word writes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mac_configuration  <= RST_WORD;
         phy_glue_config    <= RST_GLUE;
         rgmii_delay_config <= RST_DLY;
      end
      else if (reg_wr_i)
      begin
         if (sel_mac)
            mac_configuration <= reg_wdata_i;
         if (sel_glue)
            phy_glue_config <= reg_wdata_i[15:0];
         if (sel_dly)
            rgmii_delay_config <= reg_wdata_i[15:0];
      end
   end

   // =====================================================================
   // filter word pointer, shared by reads and writes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         filt_ptr <= 3'h0;
      else if (reg_wr_i && sel_pmt && reg_wdata_i[PMT_PTR_RST_BIT])
         filt_ptr <= 3'h0;
      else if ((reg_wr_i || reg_rd_i) && sel_filt && ptr_lane)
         filt_ptr <= (filt_ptr == PTR_LAST) ? 3'h0 : filt_ptr + 3'h1;
   end

   wkf_filter_mem u_mem (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .wr_i    (reg_wr_i && sel_filt),
      .ptr_i   (filt_ptr),
      .be_i    (reg_be_i),
      .wdata_i (reg_wdata_i),
      .words_o (filt_words)
   );

   // =====================================================================
   // power-down mode and wake enable; a wake frame ends power-down
   // note: no clock is gated here, the receive sampling runs throughout
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pd_mode <= 1'b0;
         wake_en <= 1'b0;
      end
      else
      begin
         if (wake_hit)
            pd_mode <= 1'b0;
         else if (reg_wr_i && sel_pmt)
            pd_mode <= reg_wdata_i[PMT_PDOWN_BIT];
         if (reg_wr_i && sel_pmt)
            wake_en <= reg_wdata_i[PMT_WAKE_EN_BIT];
      end
   end

   // sticky wake status, cleared by a status read; a new wake wins
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wake_rcvd <= 1'b0;
      else if (wake_hit)
         wake_rcvd <= 1'b1;
      else if (reg_rd_i && sel_pmt)
         wake_rcvd <= 1'b0;
   end

   // =====================================================================
   // read data, valid only in the cycle after the strobe
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         reg_rdata_o <= RST_WORD;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            OFS_MAC_CONF:  reg_rdata_o <= mac_configuration;
            OFS_WAKE_FILT: reg_rdata_o <= filt_words[filt_ptr];
            OFS_PMT_CTRL:
            begin
               reg_rdata_o                              <= RST_WORD;
               reg_rdata_o[PMT_PDOWN_BIT]               <= pd_mode;
               reg_rdata_o[PMT_WAKE_EN_BIT]             <= wake_en;
               reg_rdata_o[PMT_RCVD_BIT]                <= wake_rcvd;
               reg_rdata_o[PMT_PTR_LSB +: 3]            <= filt_ptr;
            end
            OFS_PHY_GLUE:  reg_rdata_o <= {16'h0000, phy_glue_config};
            OFS_RGMII_DLY: reg_rdata_o <= {16'h0000, rgmii_delay_config};
            default:       reg_rdata_o <= RST_WORD;  // unmapped and poll registers
         endcase
      end
      else
         reg_rdata_o <= RST_WORD;
   end

   // =====================================================================
   // mac enables, poll demand pulses and flow control
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mac_tx_en_o    <= 1'b0;
         mac_rx_en_o    <= 1'b0;
         tx_poll_o      <= 1'b0;
         rx_poll_o      <= 1'b0;
         pause_tx_o     <= 1'b0;
         backpressure_o <= 1'b0;
      end
      else
      begin
         mac_tx_en_o    <= mac_configuration[MAC_TX_EN_BIT];
         mac_rx_en_o    <= mac_configuration[MAC_RX_EN_BIT];
         tx_poll_o      <= reg_wr_i && (reg_addr_i == OFS_TX_POLL);
         rx_poll_o      <= reg_wr_i && (reg_addr_i == OFS_RX_POLL);
         pause_tx_o     <= phy_glue_config[9] && mac_configuration[MAC_DUPLEX_BIT];
         backpressure_o <= phy_glue_config[9] && !mac_configuration[MAC_DUPLEX_BIT];
      end
   end

   // =====================================================================
   // phy glue, delay-line, power-down and interrupt outputs
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         glue_o       <= '0;
         dly_o        <= '0;
         power_down_o <= 1'b0;
         pmt_irq_o    <= 1'b0;
      end
      else
      begin
         glue_o.intf_sel  <= phy_glue_config[2:0];
         glue_o.flow_ctrl <= phy_glue_config[9];
         glue_o.speed_100 <= phy_glue_config[10];
         glue_o.rmii_clk  <= phy_glue_config[11];
         glue_o.rgmii_clk <= phy_glue_config[13:12];
         glue_o.rmii_mode <= phy_glue_config[14];
         dly_o.tx_taps    <= clamp_taps(rgmii_delay_config[6:0]);
         dly_o.rx_taps    <= clamp_taps(rgmii_delay_config[13:7]);
         dly_o.tx_en      <= rgmii_delay_config[14];
         dly_o.rx_en      <= rgmii_delay_config[15];
         power_down_o     <= pd_mode;
         pmt_irq_o        <= wake_rcvd || wake_hit;
      end
   end

   // =====================================================================
   // receive link sampling: two flip-flops, then edge find
   logic [5:0] rx_meta;
   logic [5:0] rx_sync;
   logic       rx_clk_prev;
   logic       link_edge;
   logic       s_dv;
   logic [3:0] s_nib;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rx_meta     <= 6'h00;
         rx_sync     <= 6'h00;
         rx_clk_prev <= 1'b0;
      end
      else
      begin
         rx_meta     <= {rx_clk_i, rx_dv_i, rxd_i};
         rx_sync     <= rx_meta;
         rx_clk_prev <= rx_sync[5];
      end
   end

   assign link_edge = rx_sync[5] && !rx_clk_prev;
   assign s_dv      = rx_sync[4];
   assign s_nib     = rx_sync[3:0];

   // =====================================================================
   // frame framing: preamble, start delimiter, nibble pairs to bytes
   wkf_rx_e     rx_state;
   logic        half;
   logic [3:0]  low_nib;
   logic        frame_start;
   logic        byte_vld;
   logic [7:0]  rx_byte;
   logic [10:0] byte_cnt;
   logic        is_mcast;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rx_state    <= RX_IDLE;
         half        <= 1'b0;
         low_nib     <= 4'h0;
         frame_start <= 1'b0;
         byte_vld    <= 1'b0;
         rx_byte     <= 8'h00;
      end
      else
      begin
         frame_start <= 1'b0;
         byte_vld    <= 1'b0;
         case (rx_state)
            RX_IDLE:
               if (link_edge && s_dv && (s_nib == NIB_PREAMBLE))
                  rx_state <= RX_PREAMBLE;
            RX_PREAMBLE:
               if (link_edge)
               begin
                  if (!s_dv)
                     rx_state <= RX_IDLE;
                  else if (s_nib == NIB_SFD_HI)
                  begin
                     rx_state    <= RX_DATA;
                     half        <= 1'b0;
                     frame_start <= 1'b1;
                  end
               end
            RX_DATA:
               if (link_edge)
               begin
                  if (!s_dv)
                     rx_state <= RX_DONE;  // a dangling nibble is dropped
                  else if (!half)
                  begin
                     low_nib <= s_nib;
                     half    <= 1'b1;
                  end
                  else
                  begin
                     rx_byte  <= {s_nib, low_nib};
                     byte_vld <= 1'b1;
                     half     <= 1'b0;
                  end
               end
            RX_DONE:
               rx_state <= RX_IDLE;
            default:
               rx_state <= RX_IDLE;
         endcase
      end
   end

   // byte index in the frame and destination address type
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         byte_cnt <= 11'h000;
         is_mcast <= 1'b0;
      end
      else if (frame_start)
      begin
         byte_cnt <= 11'h000;
         is_mcast <= 1'b0;
      end
      else if (byte_vld)
      begin
         if (byte_cnt == 11'h000)
            is_mcast <= rx_byte[0];  // group bit of destination
         if (byte_cnt != BYTE_CNT_MAX)
            byte_cnt <= byte_cnt + 11'h001;
      end
   end

   // =====================================================================
   // four filters: masked CRC, command and compare
   logic [3:0] filt_match;

   for (genvar g = 0; g < 4; g++)
   begin : g_filt
      wkf_filter_s flt;
      logic [15:0] crc_val;

      assign flt = get_filter(filt_words, g);

      wkf_crc16 u_crc (
         .clk_i   (clk_i),
         .rst_i   (rst_i),
         .clear_i (frame_start),
         .en_i    (byte_vld && byte_sel(flt, byte_cnt)),
         .data_i  (rx_byte),
         .crc_o   (crc_val)
      );

      assign filt_match[g] = flt.cmd[CMD_EN_BIT]
                          && (flt.cmd[CMD_MCAST_BIT] == is_mcast)
                          && (crc_val == flt.crc);
   end

   // valid wake frame at frame end, only while armed in power-down
   assign wake_hit = (rx_state == RX_DONE) && (|filt_match)
                  && pd_mode && wake_en && mac_configuration[MAC_RX_EN_BIT];

endmodule : wkf_top

// *** testbench/wkf_phy_model.sv ***
// receive side of a nibble phy: preamble, start nibble, data, then idle
// assumes the clock stands still between frames
`timescale 1ns/1ns
module wkf_phy_model
(
   output logic       rx_clk_o,
   output logic       rx_dv_o,
   output logic [3:0] rxd_o
);
   initial
   begin
      rx_clk_o = 1'b0;
      rx_dv_o = 1'b0;
      rxd_o = 4'h0;
   end
   // one nibble per link clock, data set up on the falling half
   task automatic nib(input logic dv, input logic [3:0] v);
      rx_dv_o <= dv;
      rxd_o <= v;
      #160 rx_clk_o <= 1'b1;
      #160 rx_clk_o <= 1'b0;
   endtask : nib
   // whole frame, low nibble first, data inverted once released
   task automatic send(input logic [7:0] b[$]);
      repeat (15) nib(1'b1, 4'h5);
      nib(1'b1, 4'hD);
      foreach (b[i])
      begin
         nib(1'b1, b[i][3:0]);
         nib(1'b1, b[i][7:4]);
      end
      nib(1'b0, ~rxd_o);
      nib(1'b0, ~rxd_o);
   endtask : send
endmodule : wkf_phy_model

// *** testbench/wkf_sva.sv ***
// checker for register port, poll pulses, glue and wake outputs of wkf_top
// assumes it is bound to wkf_top and sees only its ports
`timescale 1ns/1ns
module wkf_sva
   import wkf_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        mac_tx_en_o,
   input wire logic        tx_poll_o,
   input wire logic        rx_poll_o,
   input wire logic        pause_tx_o,
   input wire logic        backpressure_o,
   input wkf_glue_s        glue_o,
   input wkf_dly_s         dly_o,
   input wire logic        power_down_o,
   input wire logic        pmt_irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // =====================================================================
   // register port
   property p_rdata_idle;
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_tx_poll;
      reg_wr_i && reg_addr_i == OFS_TX_POLL |=> tx_poll_o;
   endproperty
   a_tx_poll: assert property (p_tx_poll) else $error("tx poll pulse missing");
   property p_rx_poll;
      rx_poll_o |-> $past(reg_wr_i) && $past(reg_addr_i) == OFS_RX_POLL;
   endproperty
   a_rx_poll: assert property (p_rx_poll) else $error("rx poll without write");
   property p_tx_enable;
      logic v;
      (reg_wr_i && reg_addr_i == OFS_MAC_CONF, v = reg_wdata_i[MAC_TX_EN_BIT])
         |-> ##2 mac_tx_en_o == v;
   endproperty
   a_tx_enable: assert property (p_tx_enable) else $error("tx enable not updated");
   // =====================================================================
   // glue outputs
   property p_flow;
      pause_tx_o || backpressure_o |-> glue_o.flow_ctrl && !(pause_tx_o && backpressure_o);
   endproperty
   a_flow: assert property (p_flow) else $error("pause or back-pressure wrong");
   property p_taps;
      dly_o.tx_taps <= DLY_TAP_MAX && dly_o.rx_taps <= DLY_TAP_MAX;
   endproperty
   a_taps: assert property (p_taps) else $error("delay taps beyond last");
   // =====================================================================
   // wake and interrupt
   sequence s_wake_exit;
      power_down_o ##1 !power_down_o;
   endsequence
   property p_wake;
      $rose(pmt_irq_o) |-> s_wake_exit;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without power-down exit");
   property p_irq_clr;
      reg_rd_i && reg_addr_i == OFS_PMT_CTRL |-> ##2 !pmt_irq_o;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
endmodule : wkf_sva

bind wkf_top wkf_sva wkf_sva_i (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .reg_rd_i, .reg_rdata_o, .mac_tx_en_o, .tx_poll_o, .rx_poll_o, .pause_tx_o,
   .backpressure_o, .glue_o, .dly_o, .power_down_o, .pmt_irq_o);

// *** testbench/wkf_top_test.sv ***
// self-checking bench for wkf_top: registers, filter store, glue and wake frames
// assumes wkf_phy_model drives the receive link
`timescale 1ns/1ns
module wkf_top_test
   import wkf_pkg::*;
();
   logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d, w [8];
   logic [3:0] reg_be_i = 4'h0, rxd_i, cmd;
   logic rx_clk_i, rx_dv_i, mac_tx_en_o, mac_rx_en_o, tx_poll_o, rx_poll_o;
   logic pause_tx_o, backpressure_o, power_down_o, pmt_irq_o;
   wkf_glue_s glue_o;
   wkf_dly_s dly_o;
   logic [15:0] e;
   logic [30:0] m;
   logic [7:0] fr[$];
   logic [7:0] ad [6] = '{8'h00, 8'h2C, 8'h30, 8'h34, 8'h28, 8'h3C};
   int n_fail = 0, n_checks = 0, seed = 49750, f;

   wkf_top wkf_top_i (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_be_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .rx_clk_i, .rx_dv_i, .rxd_i, .mac_tx_en_o, .mac_rx_en_o,
      .tx_poll_o, .rx_poll_o, .pause_tx_o, .backpressure_o, .glue_o, .dly_o,
      .power_down_o, .pmt_irq_o);
   wkf_phy_model phy_i (.rx_clk_o(rx_clk_i), .rx_dv_o(rx_dv_i), .rxd_o(rxd_i));

   // clock and watchdog
   always #20 clk_i = ~clk_i;
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      close_out();
   end

   // =====================================================================
   // shared tasks and expectations
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
      @(posedge clk_i);
      {reg_addr_i, reg_wdata_i, reg_be_i, reg_wr_i} <= {a, v, be, 1'b1};
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk_i);
      {reg_addr_i, reg_be_i, reg_rd_i} <= {a, 4'hF, 1'b1};
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, x);
   endtask : rc
   function automatic logic [6:0] cl(input logic [6:0] v);
      return (v > 7'h63) ? 7'h63 : v;
   endfunction : cl
   function automatic logic [15:0] crc_of(input logic [7:0] b[$], input logic [30:0] k);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int j = 0; j < 31; j++)
         if (k[j])
         begin
            c ^= {8'h00, b[12 + j]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      return c;
   endfunction : crc_of
   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // =====================================================================
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ad[i]) rc(ad[i], 32'h0);
      wr(8'h3C, $random(seed), 4'hF);
      rc(8'h3C, 32'h0);
      wr(8'h2C, 32'h8000_0000, 4'hF);
      foreach (w[i]) w[i] = $random(seed);
      foreach (w[i]) wr(8'h28, w[i], 4'hF);
      wr(8'h28, 32'hA5A5_A5A5, 4'h7);
      w[0][23:0] = 24'hA5A5A5;
      for (int i = 0; i < 9; i++) rc(8'h28, w[i % 8]);
      wr(8'h00, 32'h0010_0000, 4'hF);
      wr(8'h28, 32'h0000_005A, 4'h1);
      rc(8'h28, w[2]);
      $display("filter store test done");
      for (int i = 0; i < 4; i++)
      begin
         d = $random(seed);
         d[9] = i[1];
         e = (i == 0) ? 16'hFFFF : d[15:0];
         wr(8'h00, {20'h0, i[0], 11'h00C}, 4'hF);
         wr(8'h30, d, 4'hF);
         wr(8'h34, {16'h0, e}, 4'hF);
         repeat (2) @(posedge clk_i);
         #1 chk(32'({mac_tx_en_o, mac_rx_en_o, pause_tx_o, backpressure_o}),
            {28'h0, 2'b11, i[1] & i[0], i[1] & !i[0]});
         chk(32'(glue_o), {23'h0, d[14:9], d[2:0]});
         chk(32'(dly_o), {16'h0, e[15:14], cl(e[13:7]), cl(e[6:0])});
         rc(8'h34, {16'h0, e});
      end
      wr(8'h04, 32'h0, 4'hF);
      #1 chk(32'(tx_poll_o), 32'h1);
      wr(8'h08, 32'h0, 4'hF);
      #1 chk(32'(rx_poll_o), 32'h1);
      $display("glue test done");
      for (int k = 0; k < 3; k++)
      begin
         fr.delete();
         repeat (44) fr.push_back(8'($random(seed)));
         fr[0][0] = (k != 0);
         m = 31'($random(seed));
         cmd = (k == 1) ? 4'h9 : 4'h1;
         f = (k + 3) % 4;
         w = '{default: 32'h0};
         w[f] = {1'b0, m};
         w[4][f*8 +: 4] = cmd;
         w[5] = 32'h0C0C_0C0C;
         w[6 + f/2][(f%2)*16 +: 16] = crc_of(fr, m);
         wr(8'h00, 32'h0000_0004, 4'hF);
         wr(8'h2C, 32'h8000_0005, 4'hF);
         foreach (w[i]) wr(8'h28, w[i], 4'hF);
         phy_i.send(fr);
         for (int t = 0; t < 60 && pmt_irq_o !== 1'b1; t++) @(posedge clk_i);
         #1 chk(32'(pmt_irq_o), 32'(k != 2));
         @(posedge clk_i);
         #1 chk(32'(power_down_o), 32'(k == 2));
         rc(8'h2C, (k == 2) ? 32'h0000_0005 : 32'h0000_0044);
         @(posedge clk_i);
         #1 chk(32'(pmt_irq_o), 32'h0);
      end
      $display("wake test done");
      close_out();
   end
endmodule : wkf_top_test
